// >>> src/rwpc_pkg.sv
// Shared constants and types for the reset, wake-up and power control block
package rwpc_pkg;
   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int CLK_MHZ = 125;
   // Default wake-up count on the oscillator-qualified clock
   localparam int WAKE_CYCLES_DEF = 2048;
   // Reset pin must hold a new level this many nanoseconds before it is believed
   localparam int GLITCH_NS = 80;
   localparam int GLITCH_CYCLES = (GLITCH_NS * CLK_MHZ) / 1000;
   localparam int GLITCH_W = 8;

   // ****************************************
   // Code security
   // ****************************************
   localparam logic [31:0] SECURE_KEY = 32'h87654321;
   localparam logic [11:0] SECURE_KEY_ADDR = 12'h1FC;
   localparam logic [31:0] RESET_VECTOR_ADDR = 32'h00000000;

   // ****************************************
   // Software settings and their reset values
   // ****************************************
   typedef enum logic [1:0] {
      RWPC_DIV_QUARTER = 2'h0,
      RWPC_DIV_FULL = 2'h1,
      RWPC_DIV_HALF = 2'h2
   } rwpc_div_t;
   localparam rwpc_div_t PCLK_DIV_RESET = RWPC_DIV_QUARTER;
   localparam logic [1:0] DIV_CNT_HALF_LAST = 2'h1;
   localparam logic [1:0] DIV_CNT_QUARTER_LAST = 2'h3;

   typedef enum logic {
      RWPC_MAP_FLASH = 1'h0,
      RWPC_MAP_SRAM = 1'h1
   } rwpc_map_t;
   localparam rwpc_map_t VECTOR_MAP_RESET = RWPC_MAP_FLASH;

   typedef enum logic [1:0] {
      RWPC_PWR_RUN = 2'h0,
      RWPC_PWR_IDLE = 2'h1,
      RWPC_PWR_DOWN = 2'h2,
      RWPC_PWR_WAKE = 2'h3
   } rwpc_pwr_t;

   localparam int NUM_EINT = 3;
   localparam int NUM_CAP = 10;
   localparam int NUM_PERIPH_DEF = 8;
endpackage : rwpc_pkg

// >>> src/rwpc_top.sv
// Reset sequencing, wake-up timer, power modes, wake sources and peripheral clock division
`timescale 1ns/1ps
module rwpc_top #(
   parameter int WAKE_CYCLES = rwpc_pkg::WAKE_CYCLES_DEF,
   parameter int NUM_PERIPH = rwpc_pkg::NUM_PERIPH_DEF
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ext_reset_n_i,
   input wire logic wdt_reset_i,
   input wire logic osc_running_i,
   input wire logic flash_init_done_i,
   input wire logic flash_word_valid_i,
   input wire logic flash_checksum_ok_i,
   input wire logic [31:0] flash_word_i,
   input wire logic in_system_programming_erase_i,
   input wire logic [rwpc_pkg::NUM_EINT-1:0] eint_i,
   input wire logic [rwpc_pkg::NUM_EINT-1:0] eint_level_mode_i,
   input wire logic [rwpc_pkg::NUM_EINT-1:0] eint_wake_en_i,
   input wire logic [rwpc_pkg::NUM_EINT-1:0] eint_clear_i,
   input wire logic [rwpc_pkg::NUM_CAP-1:0] cap_i,
   input wire logic [rwpc_pkg::NUM_CAP-1:0] cap_int_en_i,
   input wire logic [rwpc_pkg::NUM_CAP-1:0] cap_clear_i,
   input wire logic periph_irq_i,
   input wire logic pclk_div_wr_i,
   input wire logic [1:0] pclk_div_i,
   input wire logic vector_map_wr_i,
   input wire logic vector_map_i,
   input wire logic periph_enable_wr_i,
   input wire logic [NUM_PERIPH-1:0] periph_enable_i,
   input wire logic idle_req_i,
   input wire logic pdown_req_i,
   input wire logic pll_running_i,
   input wire logic rtc_use_ext32k_i,
   output logic chip_reset_n_o,
   output logic [31:0] reset_vector_o,
   output logic cpu_clock_en_o,
   output logic pclk_en_o,
   output logic [NUM_PERIPH-1:0] periph_clk_en_o,
   output logic osc_enable_o,
   output logic pll_keep_o,
   output logic rtc_active_o,
   output logic pins_hold_o,
   output logic debug_disable_o,
   output logic vector_map_sram_o,
   output logic [1:0] pclk_div_o,
   output logic [1:0] power_state_o,
   output logic [rwpc_pkg::NUM_EINT-1:0] eint_flag_o,
   output logic [rwpc_pkg::NUM_CAP-1:0] cap_flag_o,
   output logic irq_o
);
   localparam int WCNT_W = $clog2(WAKE_CYCLES + 1);
   localparam logic [WCNT_W-1:0] WAKE_LAST = WCNT_W'(WAKE_CYCLES - 1);
   localparam logic [rwpc_pkg::GLITCH_W-1:0] GLITCH_LAST = rwpc_pkg::GLITCH_W'(rwpc_pkg::GLITCH_CYCLES - 1);

   typedef enum logic [2:0] {
      ST_WAIT_OSC,
      ST_WAKE_COUNT,
      ST_WAIT_FLASH,
      ST_RUN,
      ST_IDLE,
      ST_PDOWN
   } rwpc_state_t;

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic ext_meta, ext_sync, osc_meta, osc_sync;
   logic [rwpc_pkg::NUM_EINT-1:0] eint_meta, eint_sync, eint_prev;
   logic [rwpc_pkg::NUM_CAP-1:0] cap_meta, cap_sync, cap_prev;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         osc_meta <= 1'b0;
         osc_sync <= 1'b0;
         eint_meta <= '0;
         eint_sync <= '0;
         cap_meta <= '0;
         cap_sync <= '0;
      end else begin
         ext_meta <= ext_reset_n_i;
         ext_sync <= ext_meta;
         osc_meta <= osc_running_i;
         osc_sync <= osc_meta;
         eint_meta <= eint_i;
         eint_sync <= eint_meta;
         cap_meta <= cap_i;
         cap_sync <= cap_meta;
      end
   end

   // ****************************************
   // Reset pin glitch filter
   // ****************************************
   logic ext_filt_n;
   logic [rwpc_pkg::GLITCH_W-1:0] glitch_cnt;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ext_filt_n <= 1'b0;
         glitch_cnt <= '0;
      end else if (ext_sync == ext_filt_n) begin
         glitch_cnt <= '0;
      end else if (glitch_cnt == GLITCH_LAST) begin
         ext_filt_n <= ext_sync;
         glitch_cnt <= '0;
      end else begin
         glitch_cnt <= glitch_cnt + 1'b1;
      end
   end

   logic reset_src;
   assign reset_src = !ext_filt_n || wdt_reset_i;

   // ****************************************
   // Interrupt and wake sources
   // ****************************************
   logic any_irq, pd_wake;

   // edge or level external interrupts, set wins over clear
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         eint_prev <= '0;
         eint_flag_o <= '0;
      end else begin
         eint_prev <= eint_sync;
         for (int i = 0; i < rwpc_pkg::NUM_EINT; i++) begin
            if (eint_level_mode_i[i]) begin
               eint_flag_o[i] <= eint_sync[i];
            end else if (eint_sync[i] && !eint_prev[i]) begin
               eint_flag_o[i] <= 1'b1;
            end else if (eint_clear_i[i]) begin
               eint_flag_o[i] <= 1'b0;
            end
         end
      end
   end

   // capture inputs as interrupts, not Power-down wake sources
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cap_prev <= '0;
         cap_flag_o <= '0;
      end else begin
         cap_prev <= cap_sync;
         cap_flag_o <= (cap_flag_o & ~cap_clear_i) | (cap_sync & ~cap_prev & cap_int_en_i);
      end
   end

   assign any_irq = (|eint_flag_o) || (|cap_flag_o) || periph_irq_i;
   // only wake-enabled external interrupts or a reset source end Power-down
   assign pd_wake = |(eint_flag_o & eint_wake_en_i);
   assign irq_o = any_irq;

   // ****************************************
   // Power and reset sequencer
   // ****************************************
   rwpc_state_t state, next_state;
   logic from_reset, next_from_reset;
   logic [WCNT_W-1:0] wake_cnt;

   always_comb begin
      next_state = state;
      next_from_reset = from_reset;
      // any reset source restarts the sequence
      if (reset_src) begin
         next_state = ST_WAIT_OSC;
         next_from_reset = 1'b1;
      end else begin
         case (state)
            ST_WAIT_OSC: begin
               if (osc_sync) begin
                  next_state = ST_WAKE_COUNT;
               end
            end
            ST_WAKE_COUNT: begin
               if (!osc_sync) begin
                  next_state = ST_WAIT_OSC;
               end else if (wake_cnt == WAKE_LAST) begin
                  next_state = from_reset ? ST_WAIT_FLASH : ST_RUN;
               end
            end
            // flash must finish before reset release
            ST_WAIT_FLASH: begin
               // Oscillator loss here must not let reset go; rerun the wake timer instead
               if (!osc_sync) begin
                  next_state = ST_WAIT_OSC;
               end else if (flash_init_done_i) begin
                  next_state = ST_RUN;
                  next_from_reset = 1'b0;
               end
            end
            ST_RUN: begin
               if (pdown_req_i) begin
                  next_state = ST_PDOWN;
               end else if (idle_req_i) begin
                  next_state = ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (any_irq) begin
                  next_state = ST_RUN;
               end
            end
            // wake from Power-down reruns the wake timer
            ST_PDOWN: begin
               if (pd_wake) begin
                  next_state = ST_WAIT_OSC;
               end
            end
            default: begin
               next_state = ST_WAIT_OSC;
               next_from_reset = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= ST_WAIT_OSC;
         from_reset <= 1'b1;
      end else begin
         state <= next_state;
         from_reset <= next_from_reset;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wake_cnt <= '0;
      end else if (state == ST_WAKE_COUNT && next_state == ST_WAKE_COUNT) begin
         wake_cnt <= wake_cnt + 1'b1;
      end else begin
         wake_cnt <= '0;
      end
   end

   // internal reset held until the sequence completes
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         chip_reset_n_o <= 1'b0;
      end else begin
         chip_reset_n_o <= !next_from_reset;
      end
   end

   // fetch starts at the reset vector
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reset_vector_o <= rwpc_pkg::RESET_VECTOR_ADDR;
      end else begin
         reset_vector_o <= rwpc_pkg::RESET_VECTOR_ADDR;
      end
   end

   // ****************************************
   // Software settings
   // ****************************************
   logic in_reset;
   assign in_reset = !chip_reset_n_o;

   // settings forced to reset values while internal reset holds
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pclk_div_o <= rwpc_pkg::PCLK_DIV_RESET;
      end else if (in_reset) begin
         pclk_div_o <= rwpc_pkg::PCLK_DIV_RESET;
      end else if (pclk_div_wr_i) begin
         pclk_div_o <= pclk_div_i;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         vector_map_sram_o <= rwpc_pkg::VECTOR_MAP_RESET;
      end else if (in_reset) begin
         vector_map_sram_o <= rwpc_pkg::VECTOR_MAP_RESET;
      end else if (vector_map_wr_i) begin
         vector_map_sram_o <= vector_map_i;
      end
   end

   logic [NUM_PERIPH-1:0] periph_on;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         periph_on <= '1;
      end else if (in_reset) begin
         periph_on <= '1;
      end else if (periph_enable_wr_i) begin
         periph_on <= periph_enable_i;
      end
   end

   // ****************************************
   // Debug lock
   // ****************************************
   // key check while internal reset holds; only an erase unlocks, a match wins
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         debug_disable_o <= 1'b0;
      end else if (in_reset && flash_word_valid_i && flash_checksum_ok_i
                   && flash_word_i == rwpc_pkg::SECURE_KEY) begin
         debug_disable_o <= 1'b1;
      end else if (in_system_programming_erase_i) begin
         debug_disable_o <= 1'b0;
      end
   end

   // ****************************************
   // Peripheral clock divider and gating
   // ****************************************
   logic [1:0] div_cnt;
   logic [1:0] div_last;
   logic clocks_on;

   // full, half or quarter rate enables
   always_comb begin
      case (pclk_div_o)
         rwpc_pkg::RWPC_DIV_FULL: div_last = '0;
         rwpc_pkg::RWPC_DIV_HALF: div_last = rwpc_pkg::DIV_CNT_HALF_LAST;
         default: div_last = rwpc_pkg::DIV_CNT_QUARTER_LAST;
      endcase
   end

   assign clocks_on = (state != ST_PDOWN);

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_cnt <= '0;
         pclk_en_o <= 1'b0;
      end else if (!clocks_on) begin
         div_cnt <= '0;
         pclk_en_o <= 1'b0;
      end else begin
         pclk_en_o <= (div_cnt >= div_last);
         div_cnt <= (div_cnt >= div_last) ? 2'h0 : div_cnt + 1'b1;
      end
   end

   // peripheral clocks keep running in Idle
   generate
      for (genvar p = 0; p < NUM_PERIPH; p++) begin : g_periph
         always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               periph_clk_en_o[p] <= 1'b0;
            end else begin
               periph_clk_en_o[p] <= clocks_on && periph_on[p] && (div_cnt >= div_last);
            end
         end
      end
   endgenerate

   // ****************************************
   // Power outputs
   // ****************************************
   // cpu clock stops in Idle and Power-down
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cpu_clock_en_o <= 1'b1;
         osc_enable_o <= 1'b1;
         pins_hold_o <= 1'b0;
         pll_keep_o <= 1'b0;
         rtc_active_o <= 1'b0;
      end else begin
         cpu_clock_en_o <= (next_state != ST_IDLE) && (next_state != ST_PDOWN);
         osc_enable_o <= (next_state != ST_PDOWN);
         pins_hold_o <= (next_state == ST_PDOWN);
         pll_keep_o <= pll_running_i && (next_state != ST_PDOWN);
         // RTC on 32 kHz survives Power-down
         rtc_active_o <= (next_state != ST_PDOWN) || rtc_use_ext32k_i;
      end
   end

   always_comb begin
      case (state)
         ST_RUN: power_state_o = rwpc_pkg::RWPC_PWR_RUN;
         ST_IDLE: power_state_o = rwpc_pkg::RWPC_PWR_IDLE;
         ST_PDOWN: power_state_o = rwpc_pkg::RWPC_PWR_DOWN;
         default: power_state_o = rwpc_pkg::RWPC_PWR_WAKE;
      endcase
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   a_wdt_reset_hold: assert property (wdt_reset_i |=> !chip_reset_n_o)
      else $error("watchdog did not assert chip reset");
   a_glitch_ignored: assert property (ext_filt_n && !ext_sync && glitch_cnt != GLITCH_LAST |=> ext_filt_n)
      else $error("short reset pulse passed the filter");
   a_release_needs_flash: assert property ($rose(chip_reset_n_o) |-> $past(flash_init_done_i))
      else $error("reset released before flash ready");
   a_release_needs_osc: assert property ($rose(chip_reset_n_o) |-> $past(osc_sync, 2))
      else $error("reset released without oscillator");
   a_vector_zero: assert property ($rose(chip_reset_n_o) |-> reset_vector_o == 32'h00000000)
      else $error("reset vector not zero");
   a_div_default: assert property ($rose(chip_reset_n_o) |-> pclk_div_o == rwpc_pkg::RWPC_DIV_QUARTER)
      else $error("divider not quarter at release");
   a_pd_wake_timer: assert property (state == ST_PDOWN && next_state != ST_PDOWN |=> state == ST_WAIT_OSC)
      else $error("Power-down exit skipped wake timer");
   a_idle_clk_off: assert property (state == ST_IDLE |-> !cpu_clock_en_o)
      else $error("cpu clock running in Idle");
   a_pd_no_pclk: assert property (state == ST_PDOWN ##1 state == ST_PDOWN |-> !pclk_en_o && !osc_enable_o)
      else $error("clock active in Power-down");
   a_cap_no_wake: assert property (state == ST_PDOWN && !reset_src && !pd_wake |=> state == ST_PDOWN)
      else $error("Power-down left without wake source");
   a_quarter_rate: assert property (pclk_en_o && clocks_on && pclk_div_o == rwpc_pkg::RWPC_DIV_QUARTER
                                    ##1 (clocks_on && pclk_div_o == rwpc_pkg::RWPC_DIV_QUARTER) [*2]
                                    |=> !pclk_en_o && !$past(pclk_en_o) && !$past(pclk_en_o, 2))
      else $error("quarter rate enable too frequent");
   a_debug_sticky: assert property (debug_disable_o && !in_system_programming_erase_i |=> debug_disable_o)
      else $error("debug lock dropped without erase");
endmodule : rwpc_top

// >>> tb/rwpc_partner.sv
// Far-side model: crystal oscillator start-up and flash controller initialisation
`timescale 1ns/1ps
module rwpc_partner (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic osc_enable_i,
   input wire logic chip_reset_n_i,
   output logic osc_running_o,
   output logic flash_init_done_o
);
   logic [2:0] osc_cnt;
   logic [4:0] flash_cnt;
   logic chip_prev;
   // ****************************************
   // Oscillator needs several cycles of amplitude build-up after enable
   // ****************************************
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         osc_cnt <= 3'h0;
      end else if (!osc_enable_i) begin
         osc_cnt <= 3'h0;
      end else if (osc_cnt != 3'h7) begin
         osc_cnt <= osc_cnt + 3'h1;
      end
   end
   assign osc_running_o = (osc_cnt == 3'h7);
   // ****************************************
   // Flash init restarts on each chip reset; slow so it is the last gate
   // ****************************************
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         flash_cnt <= 5'h00;
         chip_prev <= 1'b0;
      end else begin
         chip_prev <= chip_reset_n_i;
         if (chip_prev && !chip_reset_n_i) begin
            flash_cnt <= 5'h00;
         end else if (flash_cnt != 5'h1F) begin
            flash_cnt <= flash_cnt + 5'h01;
         end
      end
   end
   assign flash_init_done_o = (flash_cnt == 5'h1F);
endmodule : rwpc_partner

// >>> tb/testbench.sv
// Self-checking bench for the reset, wake-up and power control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin bad_count++; \
   $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end
module testbench;
   logic clk_i, reset_n_i, ext_reset_n_i, wdt_reset_i, osc_running_i, flash_init_done_i;
   logic flash_word_valid_i, flash_checksum_ok_i, in_system_programming_erase_i, periph_irq_i;
   logic [31:0] flash_word_i, reset_vector_o;
   logic [2:0] eint_i, eint_level_mode_i, eint_wake_en_i, eint_clear_i, eint_flag_o;
   logic [9:0] cap_i, cap_int_en_i, cap_clear_i, cap_flag_o;
   logic pclk_div_wr_i, vector_map_wr_i, vector_map_i, periph_enable_wr_i, idle_req_i, pdown_req_i;
   logic [1:0] pclk_div_i, pclk_div_o, power_state_o;
   logic [7:0] periph_enable_i, periph_clk_en_o;
   logic pll_running_i, rtc_use_ext32k_i, chip_reset_n_o, cpu_clock_en_o, pclk_en_o, osc_enable_o;
   logic pll_keep_o, rtc_active_o, pins_hold_o, debug_disable_o, vector_map_sram_o, irq_o;
   int bad_count = 0;
   int checks = 0;
   int n, i, k;
   int dv[4] = '{1, 2, 0, 3};
   int ex[4] = '{16, 8, 4, 4};
   logic lo;

   // Short wake count keeps the run brief
   rwpc_top #(.WAKE_CYCLES(8), .NUM_PERIPH(8)) i_rwpc_top (.*);
   rwpc_partner i_rwpc_partner (.clk_i(clk_i), .reset_n_i(reset_n_i), .osc_enable_i(osc_enable_o),
      .chip_reset_n_i(chip_reset_n_o), .osc_running_o(osc_running_i), .flash_init_done_o(flash_init_done_i));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // ****************************************
   // Helper tasks
   // ****************************************
   task tick(input int c);
      repeat (c) @(negedge clk_i);
   endtask : tick

   task wait_run(input int lim);
      for (i = 0; i < lim && !(chip_reset_n_o === 1'b1 && power_state_o === 2'h0); i++) tick(1);
   endtask : wait_run

   task set_div(input logic [1:0] v);
      pclk_div_i = v;
      pclk_div_wr_i = 1'b1;
      tick(1);
      pclk_div_wr_i = 1'b0;
      tick(1);
   endtask : set_div

   task count_pclk(output int c);
      c = 0;
      repeat (16) begin
         tick(1);
         c += (pclk_en_o === 1'b1);
      end
   endtask : count_pclk

   task complete_run();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   // Generous bound: the sequence needs well under 2000 cycles
   initial begin
      #(8 * 20000);
      bad_count++;
      complete_run();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {reset_n_i, wdt_reset_i, flash_word_valid_i, flash_checksum_ok_i, periph_irq_i} = '0;
      {in_system_programming_erase_i, pclk_div_wr_i, vector_map_wr_i, vector_map_i} = '0;
      {periph_enable_wr_i, idle_req_i, pdown_req_i, pll_running_i, rtc_use_ext32k_i} = '0;
      {eint_i, eint_level_mode_i, eint_wake_en_i, eint_clear_i, cap_i, cap_int_en_i, cap_clear_i} = '0;
      ext_reset_n_i = 1'b1;
      flash_word_i = 32'h00000000;
      pclk_div_i = 2'h0;
      periph_enable_i = 8'hFF;
      tick(6);
      reset_n_i = 1'b1;
      `CHK("vector", 32'h00000000, reset_vector_o)
      `CHK("div reset", 2'h0, pclk_div_o)
      `CHK("map reset", 1'b0, vector_map_sram_o)
      {flash_word_valid_i, flash_checksum_ok_i, flash_word_i} = {2'h3, 32'h87654320};
      tick(1);
      `CHK("lock wrong key", 1'b0, debug_disable_o)
      {flash_checksum_ok_i, flash_word_i} = {1'b0, 32'h87654321};
      tick(1);
      `CHK("lock bad sum", 1'b0, debug_disable_o)
      flash_checksum_ok_i = 1'b1;
      tick(1);
      flash_word_valid_i = 1'b0;
      `CHK("lock set", 1'b1, debug_disable_o)
      wait_run(200);
      `CHK("flash ready", 1'b1, flash_init_done_i)
      `CHK("released", 1'b1, chip_reset_n_o)
      in_system_programming_erase_i = 1'b1;
      tick(1);
      in_system_programming_erase_i = 1'b0;
      `CHK("lock erased", 1'b0, debug_disable_o)
      // ****************************************
      // Reset sources and glitch filter
      // ****************************************
      ext_reset_n_i = 1'b0;
      tick(4);
      ext_reset_n_i = 1'b1;
      lo = 1'b1;
      repeat (20) begin
         tick(1);
         lo &= chip_reset_n_o;
      end
      `CHK("glitch", 1'b1, lo)
      for (k = 0; k < 4; k++) begin
         set_div(dv[k][1:0]);
         `CHK("div setting", dv[k][1:0], pclk_div_o)
         tick(4);
         count_pclk(n);
         `CHK("pclk rate", ex[k], n)
      end
      set_div(2'h1);
      {periph_enable_i, periph_enable_wr_i, vector_map_i, vector_map_wr_i} = {8'h05, 3'h7};
      tick(1);
      {periph_enable_wr_i, vector_map_wr_i} = 2'h0;
      tick(3);
      `CHK("periph gate", 8'h05, periph_clk_en_o)
      `CHK("map sram", 1'b1, vector_map_sram_o)
      ext_reset_n_i = 1'b0;
      tick(20);
      `CHK("pin reset", 1'b0, chip_reset_n_o)
      `CHK("map cleared", 1'b0, vector_map_sram_o)
      ext_reset_n_i = 1'b1;
      wait_run(200);
      `CHK("pin release", 1'b1, chip_reset_n_o)
      `CHK("div after reset", 2'h0, pclk_div_o)
      wdt_reset_i = 1'b1;
      tick(1);
      wdt_reset_i = 1'b0;
      `CHK("wdt reset", 1'b0, chip_reset_n_o)
      wait_run(200);
      `CHK("wdt release", 1'b1, chip_reset_n_o)
      // ****************************************
      // Idle and Power-down
      // ****************************************
      {pll_running_i, idle_req_i} = 2'h3;
      tick(1);
      idle_req_i = 1'b0;
      `CHK("idle", 2'h1, power_state_o)
      `CHK("idle cpu clk", 1'b0, cpu_clock_en_o)
      `CHK("pll kept", 1'b1, pll_keep_o)
      count_pclk(n);
      `CHK("idle pclk", 4, n)
      periph_irq_i = 1'b1;
      tick(1);
      periph_irq_i = 1'b0;
      `CHK("idle exit", 2'h0, power_state_o)
      {rtc_use_ext32k_i, eint_wake_en_i, cap_int_en_i} = {1'b1, 3'h2, 10'h3FF};
      {pdown_req_i, idle_req_i} = 2'h3;
      tick(1);
      {pdown_req_i, idle_req_i} = 2'h0;
      `CHK("pdown", 2'h2, power_state_o)
      `CHK("osc off", 1'b0, osc_enable_o)
      `CHK("pins held", 1'b1, pins_hold_o)
      `CHK("rtc on", 1'b1, rtc_active_o)
      {cap_i, eint_i} = {10'h001, 3'h1};
      tick(6);
      `CHK("cap flag", 10'h001, cap_flag_o)
      `CHK("eint flag", 3'h1, eint_flag_o)
      `CHK("no wake", 2'h2, power_state_o)
      eint_i = 3'h3;
      for (i = 0; i < 10 && power_state_o !== 2'h3; i++) tick(1);
      `CHK("waking", 2'h3, power_state_o)
      for (n = 0; n < 100 && power_state_o === 2'h3; n++) tick(1);
      `CHK("wake length", 1'b1, n >= 8)
      `CHK("woke", 2'h0, power_state_o)
      `CHK("no chip reset", 1'b1, chip_reset_n_o)
      {eint_i, cap_i, eint_clear_i, cap_clear_i} = {13'h0000, 13'h1FFF};
      tick(1);
      {eint_clear_i, cap_clear_i} = 13'h0000;
      tick(1);
      `CHK("flags cleared", 1'b0, irq_o)
      {eint_level_mode_i, eint_i} = {3'h4, 3'h4};
      tick(4);
      `CHK("level flag", 3'h4, eint_flag_o)
      eint_i = 3'h0;
      tick(4);
      `CHK("level drop", 3'h0, eint_flag_o)
      complete_run();
   end
endmodule : testbench
